// file: ccr_map.svh
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH
// register offsets on the plain register port
`define CCR_ADDR_CMP_CTRL   4'h0
`define CCR_ADDR_LADDER     4'h1
`define CCR_ADDR_IRQ_STATUS 4'h2
`define CCR_ADDR_IRQ_MASK   4'h3
`define CCR_ADDR_WAKE_STAT  4'h4
// comparator control/status fields
`define CCR_CMP_OUT_LSB     5
`define CCR_CMP_EN_LSB      0
// ladder control fields
`define CCR_LAD_PWR_BIT     7
`define CCR_LAD_RANGE_BIT   5
`define CCR_LAD_SRC_BIT     4
`define CCR_LAD_LEVEL_LSB   0
// change flags sit at bits 3..1 of flag and enable registers
`define CCR_FLAG_LSB        1
// implemented-bit masks and reset values
`define CCR_CMP_WR_MASK     8'h07
`define CCR_LAD_WR_MASK     8'hBF
`define CCR_CMP_RESET       8'h00
`define CCR_LAD_RESET       8'h00
`define CCR_IRQ_RESET       8'h00
// ladder tap scaling: tap = num / den of the source span
`define CCR_LOW_RANGE_DEN   8'h18
`define CCR_HIGH_RANGE_DEN  8'h20
`define CCR_HIGH_RANGE_BASE 8'h08
`endif

// file: ccr_pkg.sv
package ccr_pkg;
  // comparator reference input routing toward the analog section
  typedef enum logic [1:0] {
    CCR_REF_NONE,
    CCR_REF_EXTERNAL,
    CCR_REF_LADDER
  } ccr_ref_route_t;
  // ladder supply choice
  typedef enum logic {
    CCR_SRC_ANALOG_SUPPLY,
    CCR_SRC_EXTERNAL_PIN
  } ccr_src_t;
endpackage

// file: ccr_comparator_reference.sv
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "ccr_map.svh"

module ccr_comparator_reference #(
  parameter int NUM_CMP = 3
) (
  input  wire logic               mclk,
  input  wire logic               resetn,
  input  wire logic [3:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  input  wire logic [NUM_CMP-1:0] comparator_raw,
  input  wire logic               sleep_active,
  output logic      [NUM_CMP-1:0] comparator_power,
  output logic                    ladder_power_on,
  output logic                    ladder_range_select,
  output ccr_pkg::ccr_src_t       ladder_source_select,
  output logic      [3:0]         ladder_level_code,
  output logic      [7:0]         ladder_tap_num,
  output logic      [7:0]         ladder_tap_den,
  output ccr_pkg::ccr_ref_route_t ref_route,
  output logic                    irq,
  output logic                    wake_request
);

  // registers
  logic [NUM_CMP-1:0] cmp_en_q;
  logic [7:0]         lad_q;
  logic [NUM_CMP-1:0] sync1_q;
  logic [NUM_CMP-1:0] sync2_q;
  logic [NUM_CMP-1:0] result_q;
  logic [NUM_CMP-1:0] latched_q;
  logic [NUM_CMP-1:0] flag_q;
  logic [NUM_CMP-1:0] mask_q;
  logic               wake_seen_q;
  logic [7:0]         rdata_q;
  logic [7:0]         tap_num_q;
  logic [7:0]         tap_den_q;
  ccr_pkg::ccr_ref_route_t route_q;
  logic               irq_q;
  logic               wake_q;

  logic               wr_cmp;
  logic               rd_cmp;
  logic               wr_lad;
  logic               wr_flag;
  logic               wr_mask;
  logic               wr_wake;
  logic [NUM_CMP-1:0] mismatch;
  logic [NUM_CMP-1:0] flag_clr;
  logic [7:0]         cmp_view;
  logic               lad_pwr;
  logic               lad_rng;
  logic               lad_src;
  logic [3:0]         lad_lvl;

  assign wr_cmp   = reg_wr && (reg_addr == `CCR_ADDR_CMP_CTRL);
  assign rd_cmp   = reg_rd && (reg_addr == `CCR_ADDR_CMP_CTRL);
  assign wr_lad   = reg_wr && (reg_addr == `CCR_ADDR_LADDER);
  assign wr_flag  = reg_wr && (reg_addr == `CCR_ADDR_IRQ_STATUS);
  assign wr_mask  = reg_wr && (reg_addr == `CCR_ADDR_IRQ_MASK);
  assign wr_wake  = reg_wr && (reg_addr == `CCR_ADDR_WAKE_STAT);
  assign lad_pwr  = lad_q[`CCR_LAD_PWR_BIT];
  assign lad_rng  = lad_q[`CCR_LAD_RANGE_BIT];
  assign lad_src  = lad_q[`CCR_LAD_SRC_BIT];
  assign lad_lvl  = lad_q[`CCR_LAD_LEVEL_LSB +: 4];
  assign flag_clr = reg_wdata[`CCR_FLAG_LSB +: NUM_CMP];
  // results and enables in their fixed slots, bits 4..3 stay zero
  assign cmp_view = {result_q, 2'b00, cmp_en_q};

  // comparator enables; sleep never touches them, only reset and writes
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      cmp_en_q <= NUM_CMP'(`CCR_CMP_RESET);
    else if (wr_cmp)
      cmp_en_q <= reg_wdata[`CCR_CMP_EN_LSB +: NUM_CMP];
  end

  // ladder control; bit 6 masked off so it can never store a one
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      lad_q <= `CCR_LAD_RESET;
    else if (wr_lad)
      lad_q <= reg_wdata & `CCR_LAD_WR_MASK;
  end

  // analog results cross into mclk through two flops; disabled reads zero
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_q  <= '0;
      sync2_q  <= '0;
      result_q <= '0;
    end
    else
    begin
      sync1_q  <= comparator_raw;
      sync2_q  <= sync1_q;
      result_q <= sync2_q & cmp_en_q;
    end
  end

  // reference copy of outputs; any access of the control register ends mismatch
  assign mismatch = result_q ^ latched_q;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      latched_q <= '0;
    else if (wr_cmp || rd_cmp)
      latched_q <= result_q;
  end

  // sticky change flags, write one to clear, a live mismatch wins over clear
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      flag_q <= NUM_CMP'(`CCR_IRQ_RESET);
    else
      flag_q <= (flag_q & ~(wr_flag ? flag_clr : '0)) | mismatch;
  end

  // interrupt mask, same layout as the flags
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      mask_q <= '0;
    else if (wr_mask)
      mask_q <= reg_wdata[`CCR_FLAG_LSB +: NUM_CMP];
  end

  // interrupt and wake stay live in sleep, no clock gating here
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      irq_q  <= |(flag_q & mask_q);
      wake_q <= sleep_active && |(flag_q & mask_q);
    end
  end

  // sticky record that a wake-up was raised, write one to clear
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      wake_seen_q <= 1'b0;
    else if (wake_q)
      wake_seen_q <= 1'b1;
    else if (wr_wake && reg_wdata[0])
      wake_seen_q <= 1'b0;
  end

  // ladder tap ratio and reference routing toward the analog section
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      tap_num_q <= `CCR_HIGH_RANGE_BASE; // reset fields mean high range, level 0
      tap_den_q <= `CCR_HIGH_RANGE_DEN;
      route_q   <= ccr_pkg::CCR_REF_NONE;
    end
    else
    begin
      if (lad_rng)
      begin
        tap_num_q <= {4'h0, lad_lvl};
        tap_den_q <= `CCR_LOW_RANGE_DEN;
      end
      else
      begin
        tap_num_q <= `CCR_HIGH_RANGE_BASE + {4'h0, lad_lvl};
        tap_den_q <= `CCR_HIGH_RANGE_DEN;
      end
      // powered ladder always feeds comparators; off only bypass or nothing
      if (lad_pwr)
        route_q <= ccr_pkg::CCR_REF_LADDER;
      else if (lad_src)
        route_q <= ccr_pkg::CCR_REF_EXTERNAL;
      else
        route_q <= ccr_pkg::CCR_REF_NONE;
    end
  end

  // read port, data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `CCR_ADDR_CMP_CTRL:   rdata_q <= cmp_view;
        `CCR_ADDR_LADDER:     rdata_q <= lad_q;
        `CCR_ADDR_IRQ_STATUS: rdata_q <= {4'h0, flag_q, 1'b0};
        `CCR_ADDR_IRQ_MASK:   rdata_q <= {4'h0, mask_q, 1'b0};
        `CCR_ADDR_WAKE_STAT:  rdata_q <= {7'h00, wake_seen_q};
        default:              rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  assign reg_rdata            = rdata_q;
  assign comparator_power     = cmp_en_q;
  assign ladder_power_on      = lad_pwr;
  assign ladder_range_select  = lad_rng;
  assign ladder_source_select = ccr_pkg::ccr_src_t'(lad_src);
  assign ladder_level_code    = lad_lvl;
  assign ladder_tap_num       = tap_num_q;
  assign ladder_tap_den       = tap_den_q;
  assign ref_route            = route_q;
  assign irq                  = irq_q;
  assign wake_request         = wake_q;

  // checks
  a_change_sets_flag: assert property (@(posedge mclk) disable iff (!resetn)
    (mismatch[0]) |=> flag_q[0])
    else $error("comparator change did not set flag");
  a_access_ends_mis: assert property (@(posedge mclk) disable iff (!resetn)
    (rd_cmp && $stable(result_q)) |=> ##0 (latched_q == $past(result_q)))
    else $error("access did not end mismatch");
  a_sleep_keeps_en: assert property (@(posedge mclk) disable iff (!resetn)
    (!$past(wr_cmp) && $fell(sleep_active)) |-> $stable(cmp_en_q))
    else $error("wake changed comparator enables");
  a_wake_on_irq: assert property (@(posedge mclk) disable iff (!resetn)
    (sleep_active && |(flag_q & mask_q)) |=> wake_request)
    else $error("no wake request in sleep");
  a_irq_follows: assert property (@(posedge mclk) disable iff (!resetn)
    (|(flag_q & mask_q)) |=> irq)
    else $error("masked flag did not raise interrupt");
  a_route_ladder: assert property (@(posedge mclk) disable iff (!resetn)
    lad_pwr |=> (ref_route == ccr_pkg::CCR_REF_LADDER))
    else $error("powered ladder not routed");
  a_route_bypass: assert property (@(posedge mclk) disable iff (!resetn)
    (!lad_pwr && lad_src) |=> (ref_route == ccr_pkg::CCR_REF_EXTERNAL))
    else $error("external bypass not routed");
  a_low_range_tap: assert property (@(posedge mclk) disable iff (!resetn)
    lad_rng |=> (ladder_tap_den == `CCR_LOW_RANGE_DEN &&
                 ladder_tap_num == {4'h0, $past(lad_lvl)}))
    else $error("low range tap wrong");
  a_high_range_tap: assert property (@(posedge mclk) disable iff (!resetn)
    !lad_rng |=> (ladder_tap_den == `CCR_HIGH_RANGE_DEN &&
                  ladder_tap_num == `CCR_HIGH_RANGE_BASE + {4'h0, $past(lad_lvl)}))
    else $error("high range tap wrong");
  a_bit6_zero: assert property (@(posedge mclk) disable iff (!resetn)
    lad_q[6] == 1'b0)
    else $error("ladder bit 6 stored a one");

endmodule
`default_nettype wire

// file: ccr_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
module ccr_analog_model #(
  parameter int EXT_LVL = 48
) (
  input  wire logic                    mclk,
  input  wire logic [2:0]              comparator_power,
  input  wire ccr_pkg::ccr_ref_route_t ref_route,
  input  wire logic [7:0]              ladder_tap_num,
  input  wire logic [7:0]              ladder_tap_den,
  input  wire logic [23:0]             vin,
  output logic      [2:0]              comparator_raw
);
  int ref_lvl;
  // known start so the junk toggling never feeds unknowns into the block
  logic [2:0] raw_q = 3'h0;
  assign comparator_raw = raw_q;
  // reference in 1/96 of the span, exact for both ladder steps
  always_comb
  begin
    case (ref_route)
      ccr_pkg::CCR_REF_LADDER:   ref_lvl = int'(ladder_tap_num) * 96 / int'(ladder_tap_den);
      ccr_pkg::CCR_REF_EXTERNAL: ref_lvl = EXT_LVL;
      default:                   ref_lvl = 0;
    endcase
  end
  // unpowered comparator output is junk, so it toggles every cycle
  always @(posedge mclk)
    for (int i = 0; i < 3; i++)
      raw_q[i] <= comparator_power[i] ? (int'(vin[i*8 +: 8]) > ref_lvl)
                                      : ~raw_q[i];
endmodule
`default_nettype wire

// file: ccr_comparator_reference_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "ccr_map.svh"
module ccr_comparator_reference_bench;
  logic                    mclk = 1'b0;
  logic                    resetn = 1'b0;
  logic [3:0]              reg_addr = 4'h0;
  logic [7:0]              reg_wdata = 8'h00;
  logic                    reg_wr = 1'b0;
  logic                    reg_rd = 1'b0;
  logic                    sleep_active = 1'b0;
  logic [23:0]             vin = 24'h000000;
  logic [7:0]              reg_rdata, tap_num, tap_den, lvl;
  logic [2:0]              raw, cmp_pwr;
  logic                    pwr, rng, irq, wake;
  logic [3:0]              level;
  ccr_pkg::ccr_src_t       src;
  ccr_pkg::ccr_ref_route_t route, exp_route;
  int                      num_errors = 0;
  int                      checked = 0;
  always #5 mclk = ~mclk;
  ccr_comparator_reference dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .comparator_raw(raw), .sleep_active(sleep_active), .comparator_power(cmp_pwr),
    .ladder_power_on(pwr), .ladder_range_select(rng), .ladder_source_select(src),
    .ladder_level_code(level), .ladder_tap_num(tap_num), .ladder_tap_den(tap_den),
    .ref_route(route), .irq(irq), .wake_request(wake));
  ccr_analog_model analog (.mclk(mclk), .comparator_power(cmp_pwr), .ref_route(route),
    .ladder_tap_num(tap_num), .ladder_tap_den(tap_den), .vin(vin), .comparator_raw(raw));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    chk("rdata", reg_rdata, exp);
    // data stands one cycle only, then the port falls back to zero
    @(posedge mclk);
    #1;
    chk("rdata_idle", reg_rdata, 8'h00);
  endtask
  // bounded wait on the sync chain and flag stages
  task automatic wait_irq;
    int n = 0;
    while (irq !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    #1;
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #100000;
    num_errors++;
    complete_run();
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    rd(`CCR_ADDR_CMP_CTRL, 8'h00);
    rd(`CCR_ADDR_LADDER, 8'h00);
    chk("route", {6'h00, route}, {6'h00, ccr_pkg::CCR_REF_NONE});
    wr(`CCR_ADDR_CMP_CTRL, 8'hFF);
    rd(`CCR_ADDR_CMP_CTRL, 8'h07);
    chk("cmp_pwr", {5'h00, cmp_pwr}, 8'h07);
    wr(`CCR_ADDR_LADDER, 8'hFF);
    rd(`CCR_ADDR_LADDER, 8'hBF);
    rd(4'hF, 8'h00);
    // every power, range and source mix; levels reach 0 and 15
    for (int i = 0; i < 8; i++)
    begin
      lvl = {4'h0, 4'(i * 5)};
      wr(`CCR_ADDR_LADDER, {i[2], 1'b0, i[1], i[0], lvl[3:0]});
      @(posedge mclk);
      #1;
      exp_route = i[2] ? ccr_pkg::CCR_REF_LADDER :
                  (i[0] ? ccr_pkg::CCR_REF_EXTERNAL : ccr_pkg::CCR_REF_NONE);
      chk("num", tap_num, i[1] ? lvl : 8'h08 + lvl);
      chk("den", tap_den, i[1] ? 8'h18 : 8'h20);
      chk("route", {6'h00, route}, {6'h00, exp_route});
      chk("fields", {pwr, 1'b0, rng, src, level}, {i[2], 1'b0, i[1], i[0], lvl[3:0]});
    end
    // enabling comparators may glitch their outputs: end mismatch, clear stale flags
    rd(`CCR_ADDR_CMP_CTRL, 8'h07);
    wr(`CCR_ADDR_IRQ_STATUS, 8'h0E);
    rd(`CCR_ADDR_IRQ_STATUS, 8'h00);
    wr(`CCR_ADDR_LADDER, 8'h80);
    wr(`CCR_ADDR_IRQ_MASK, 8'h0E);
    vin[7:0] <= 8'h30;
    wait_irq();
    chk("irq", {7'h00, irq}, 8'h01);
    wr(`CCR_ADDR_IRQ_STATUS, 8'h02);
    rd(`CCR_ADDR_IRQ_STATUS, 8'h02);
    rd(`CCR_ADDR_CMP_CTRL, 8'h27);
    wr(`CCR_ADDR_IRQ_STATUS, 8'h02);
    rd(`CCR_ADDR_IRQ_STATUS, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    // masked change still flags but stays quiet
    wr(`CCR_ADDR_IRQ_MASK, 8'h00);
    vin[7:0] <= 8'h00;
    repeat (8) @(posedge mclk);
    #1;
    chk("irq", {7'h00, irq}, 8'h00);
    rd(`CCR_ADDR_IRQ_STATUS, 8'h02);
    rd(`CCR_ADDR_CMP_CTRL, 8'h07);
    wr(`CCR_ADDR_IRQ_STATUS, 8'h02);
    wr(`CCR_ADDR_IRQ_MASK, 8'h0E);
    sleep_active <= 1'b1;
    vin[15:8] <= 8'h30;
    wait_irq();
    chk("wake", {7'h00, wake}, 8'h01);
    chk("cmp_pwr", {5'h00, cmp_pwr}, 8'h07);
    rd(`CCR_ADDR_WAKE_STAT, 8'h01);
    @(posedge mclk);
    sleep_active <= 1'b0;
    rd(`CCR_ADDR_CMP_CTRL, 8'h47);
    wr(`CCR_ADDR_CMP_CTRL, 8'h00);
    #1;
    chk("cmp_pwr", {5'h00, cmp_pwr}, 8'h00);
    // second reset in mid-run
    wr(`CCR_ADDR_CMP_CTRL, 8'h07);
    wr(`CCR_ADDR_LADDER, 8'hBF);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd(`CCR_ADDR_CMP_CTRL, 8'h00);
    rd(`CCR_ADDR_LADDER, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
